// ==== core/ptm_consts.svh ====
// ptm_consts.svh: register offsets, control bit positions and reset values
// assumes a 32-bit register port addressed in bytes, one register per word
`ifndef PTM_CONSTS_SVH
`define PTM_CONSTS_SVH

`define PTM_ADDR_W     8
`define PTM_OFF_CTL0   8'h00
`define PTM_OFF_CTL4   8'h04
`define PTM_OFF_EXTF   8'h08
`define PTM_OFF_BASELO 8'h0C
`define PTM_OFF_BASEHI 8'h10
`define PTM_OFF_STAT   8'h14
`define PTM_OFF_LASTLO 8'h18
`define PTM_OFF_LASTHI 8'h1C
`define PTM_OFF_WALKS  8'h20

`define PTM_BIT_PG     31
`define PTM_BIT_PAE    5
`define PTM_BIT_PSE    4
`define PTM_BIT_LME    8
`define PTM_BIT_LMA    10
`define PTM_BIT_PS     7

`define PTM_RST_BIT    1'b0
`define PTM_RST_WORD   32'h0000_0000
`define PTM_RST_HI     20'h0_0000
`define PTM_RST_PA     52'h0_0000_0000_0000

`endif

// ==== core/ptm_pkg.sv ====
// ptm_pkg: types shared by the page translation mode select block
// assumes the walk side returns whole 64-bit entries, low word first in use
package ptm_pkg;

    typedef enum logic [1:0] {PM_OFF, PM_LEG32, PM_LEGPAE, PM_LONG} ptm_mode_e;
    typedef enum logic [1:0] {PS_4K, PS_2M, PS_4M, PS_1G} ptm_size_e;
    typedef enum logic [1:0] {WS_IDLE, WS_FETCH} ptm_walk_e;

    typedef struct packed {
        logic        valid;
        logic [63:0] vaddr;
    } ptm_req_s;

    typedef struct packed {
        logic        valid;
        logic [51:0] paddr;
        ptm_size_e   size;
    } ptm_rsp_s;

    typedef struct packed {
        logic        valid;
        logic [51:0] addr;
        logic        wide;
    } ptm_fetch_s;

    typedef struct packed {
        logic        valid;
        logic [63:0] data;
    } ptm_mem_s;

    typedef struct packed {
        logic        pg;
        logic        phys_addr_extension_bit;
        logic        large_page_size_ext_bit;
        logic        lme;
        logic [31:0] baseLo;
        logic [19:0] baseHi;
        logic [31:0] rdData;
        ptm_walk_e   walk;
        logic [2:0]  level;
        ptm_mode_e   mode;
        logic [47:0] vaddr;
        ptm_fetch_s  fetch;
        ptm_rsp_s    rsp;
        logic [51:0] lastPa;
        logic [31:0] walks;
    } ptm_state_s;

endpackage

// ==== core/ptm_translate_core.sv ====
// ptm_translate_core: paging mode select and table walk sequencer
// assumes request, register and walk-side inputs come from mclk logic
// assumes software enables extensions before it enables long mode
//
// Decided for this implementation: strobed register access and the address map.
`include "ptm_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module ptm_translate_core #(
    parameter int PA_W = 52
) (
    input  wire logic                    mclk,
    input  wire logic                    rstn,
    input  wire logic                    ce,
    input  wire logic [`PTM_ADDR_W-1:0]  regAddr,
    input  wire logic [31:0]             regWData,
    input  wire logic                    regWr,
    input  wire logic                    regRd,
    output logic      [31:0]             regRData,
    input  wire ptm_pkg::ptm_req_s       req,
    output logic                         reqReady,
    output ptm_pkg::ptm_rsp_s            rsp,
    output logic      [PA_W-1:0]         rspPaddr,
    output ptm_pkg::ptm_fetch_s          fetch,
    input  wire ptm_pkg::ptm_mem_s       mem,
    output ptm_pkg::ptm_mode_e           modeNow,
    output logic                         longActive
);

    if (PA_W < 40 || PA_W > 52) begin : gBadPaW
        $error("PA_W must lie between 40 and 52");
    end

    localparam logic [3:0] RI_NONE   = 4'h0;
    localparam logic [3:0] RI_CTL0   = 4'h1;
    localparam logic [3:0] RI_CTL4   = 4'h2;
    localparam logic [3:0] RI_EXTF   = 4'h3;
    localparam logic [3:0] RI_BASELO = 4'h4;
    localparam logic [3:0] RI_BASEHI = 4'h5;
    localparam logic [3:0] RI_STAT   = 4'h6;
    localparam logic [3:0] RI_LASTLO = 4'h7;
    localparam logic [3:0] RI_LASTHI = 4'h8;
    localparam logic [3:0] RI_WALKS  = 4'h9;

    // register slot of a bus address, none for unmapped offsets
    function automatic logic [3:0] regIndex(
        input logic [`PTM_ADDR_W-1:0] a
    );
        logic [3:0] i;
        unique case (a)
            `PTM_OFF_CTL0: i = RI_CTL0;
            `PTM_OFF_CTL4: i = RI_CTL4;
            `PTM_OFF_EXTF: i = RI_EXTF;
            `PTM_OFF_BASELO: i = RI_BASELO;
            `PTM_OFF_BASEHI: i = RI_BASEHI;
            `PTM_OFF_STAT: i = RI_STAT;
            `PTM_OFF_LASTLO: i = RI_LASTLO;
            `PTM_OFF_LASTHI: i = RI_LASTHI;
            `PTM_OFF_WALKS: i = RI_WALKS;
            default: i = RI_NONE;
        endcase
        return i;
    endfunction

    // address of the table entry fetched at a given level
    function automatic logic [51:0] tableAddr(
        input ptm_pkg::ptm_mode_e m,
        input logic [2:0]         lvl,
        input logic [51:0]        base,
        input logic [47:0]        va
    );
        logic [51:0] a;
        a = 52'h0_0000_0000_0000;
        if (m == ptm_pkg::PM_LEG32) begin
            if (lvl == 3'h2) begin
                a = {base[51:12], va[31:22], 2'h0};
            end else begin
                a = {base[51:12], va[21:12], 2'h0};
            end
        end else begin
            unique case (lvl)
                3'h4: a = {base[51:12], va[47:39], 3'h0};
                3'h3: begin
                    if (m == ptm_pkg::PM_LONG) begin
                        a = {base[51:12], va[38:30], 3'h0};
                    end else begin
                        a = {base[51:5], va[31:30], 3'h0};
                    end
                end
                3'h2: a = {base[51:12], va[29:21], 3'h0};
                default: a = {base[51:12], va[20:12], 3'h0};
            endcase
        end
        return a;
    endfunction

    // large pages allowed for a mode and the page-size extension control
    function automatic logic largeAllowed(
        input ptm_pkg::ptm_mode_e m,
        input logic               large_page_size_ext_bit
    );
        logic ok;
        unique case (m)
            ptm_pkg::PM_LEG32: ok = large_page_size_ext_bit;
            ptm_pkg::PM_OFF: ok = 1'b0;
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction

    // large page size in force for a mode
    function automatic ptm_pkg::ptm_size_e largeOf(
        input ptm_pkg::ptm_mode_e m
    );
        ptm_pkg::ptm_size_e s;
        unique case (m)
            ptm_pkg::PM_LEG32: s = ptm_pkg::PS_4M;
            ptm_pkg::PM_OFF: s = ptm_pkg::PS_4K;
            default: s = ptm_pkg::PS_2M;
        endcase
        return s;
    endfunction

    logic [1:0] rstSync;
    logic       rstnInt;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end

    assign rstnInt = rstSync[1];

    ptm_pkg::ptm_state_s q;
    ptm_pkg::ptm_state_s d;

    logic                long_mode_active_flag;
    ptm_pkg::ptm_mode_e  curMode;
    logic                largeOk;
    ptm_pkg::ptm_size_e  largeSize;
    logic [51:0]         startBase;
    logic [2:0]          startLevel;
    logic [63:0]         entry;
    logic [51:0]         nextBase;
    logic                psBit;
    logic                leaf;
    ptm_pkg::ptm_size_e  leafSize;
    logic [51:0]         leafPa;
    logic                walkLong;
    logic                walkLarge;
    logic [31:0]         rdValue;

    // long mode active follows the paging bit while long mode is enabled
    always_comb begin
        long_mode_active_flag = q.lme & q.pg;
    end

    always_comb begin
        if (!q.pg) begin
            curMode = ptm_pkg::PM_OFF;
        end else if (long_mode_active_flag) begin
            curMode = ptm_pkg::PM_LONG;
        end else if (q.phys_addr_extension_bit) begin
            curMode = ptm_pkg::PM_LEGPAE;
        end else begin
            curMode = ptm_pkg::PM_LEG32;
        end
    end

    // large page size in force for the current controls
    always_comb begin
        largeOk = largeAllowed(curMode, q.large_page_size_ext_bit);
        largeSize = largeOf(curMode);
    end

    always_comb begin
        unique case (curMode)
            ptm_pkg::PM_LONG: begin
                startBase = {q.baseHi, q.baseLo[31:12], 12'h000};
                startLevel = 3'h4;
            end
            ptm_pkg::PM_LEGPAE: begin
                startBase = {20'h0_0000, q.baseLo[31:5], 5'h00};
                startLevel = 3'h3;
            end
            default: begin
                startBase = {20'h0_0000, q.baseLo[31:12], 12'h000};
                startLevel = 3'h2;
            end
        endcase
    end

    // entry decode for the walk in progress
    always_comb begin
        walkLong = (q.mode == ptm_pkg::PM_LONG);
        walkLarge = largeAllowed(q.mode, q.large_page_size_ext_bit);
        if (q.mode == ptm_pkg::PM_LEG32) begin
            entry = {32'h0000_0000, mem.data[31:0]};
        end else begin
            entry = mem.data;
        end
        nextBase = {entry[51:12], 12'h000};
        psBit = entry[`PTM_BIT_PS];
        leaf = 1'b0;
        leafSize = ptm_pkg::PS_4K;
        leafPa = {entry[51:12], q.vaddr[11:0]};
        unique case (q.level)
            3'h1: begin
                leaf = 1'b1;
            end
            3'h2: begin
                if (psBit && walkLarge) begin
                    leaf = 1'b1;
                    leafSize = largeOf(q.mode);
                    if (q.mode == ptm_pkg::PM_LEG32) begin
                        leafPa = {12'h000, entry[20:13], entry[31:22], q.vaddr[21:0]};
                    end else begin
                        leafPa = {entry[51:21], q.vaddr[20:0]};
                    end
                end
            end
            3'h3: begin
                if (psBit && walkLong) begin
                    leaf = 1'b1;
                    leafSize = ptm_pkg::PS_1G;
                    leafPa = {entry[51:30], q.vaddr[29:0]};
                end
            end
            default: leaf = 1'b0;
        endcase
    end

    always_comb begin
        unique case (regIndex(regAddr))
            RI_CTL0: rdValue = {q.pg, 31'h0000_0000};
            RI_CTL4: rdValue = {26'h000_0000, q.phys_addr_extension_bit, q.large_page_size_ext_bit, 4'h0};
            RI_EXTF: rdValue = {21'h00_0000, long_mode_active_flag, 1'b0, q.lme, 8'h00};
            RI_BASELO: rdValue = q.baseLo;
            RI_BASEHI: rdValue = {12'h000, q.baseHi};
            RI_STAT: rdValue = {24'h00_0000, q.walk == ptm_pkg::WS_FETCH, q.level, largeOk,
                                largeSize, curMode == ptm_pkg::PM_OFF};
            RI_LASTLO: rdValue = q.lastPa[31:0];
            RI_LASTHI: rdValue = {12'h000, q.lastPa[51:32]};
            RI_WALKS: rdValue = q.walks;
            default: rdValue = 32'h0000_0000;
        endcase
    end

    always_comb begin
        d = q;
        d.rsp.valid = 1'b0;
        d.rdData = 32'h0000_0000;
        if (regRd) begin
            d.rdData = rdValue;
        end
        if (regWr) begin
            unique case (regIndex(regAddr))
                RI_CTL0: d.pg = regWData[`PTM_BIT_PG];
                RI_CTL4: begin
                    d.phys_addr_extension_bit = regWData[`PTM_BIT_PAE];
                    d.large_page_size_ext_bit = regWData[`PTM_BIT_PSE];
                end
                RI_EXTF: d.lme = regWData[`PTM_BIT_LME];
                RI_BASELO: d.baseLo = regWData;
                RI_BASEHI: d.baseHi = regWData[19:0];
                default: d.walks = q.walks;
            endcase
        end
        unique case (q.walk)
            ptm_pkg::WS_IDLE: begin
                if (req.valid) begin
                    if (curMode == ptm_pkg::PM_OFF) begin
                        d.rsp.valid = 1'b1;
                        d.rsp.paddr = {20'h0_0000, req.vaddr[31:0]};
                        d.rsp.size = ptm_pkg::PS_4K;
                        d.lastPa = {20'h0_0000, req.vaddr[31:0]};
                    end else begin
                        d.mode = curMode;
                        d.level = startLevel;
                        if (curMode == ptm_pkg::PM_LONG) begin
                            d.vaddr = req.vaddr[47:0];
                        end else begin
                            d.vaddr = {16'h0000, req.vaddr[31:0]};
                        end
                        d.fetch.valid = 1'b1;
                        d.fetch.wide = (curMode != ptm_pkg::PM_LEG32);
                        d.fetch.addr = tableAddr(curMode, startLevel, startBase, d.vaddr);
                        d.walk = ptm_pkg::WS_FETCH;
                    end
                end
            end
            ptm_pkg::WS_FETCH: begin
                if (mem.valid) begin
                    if (leaf) begin
                        d.fetch.valid = 1'b0;
                        d.rsp.valid = 1'b1;
                        d.rsp.paddr = leafPa;
                        d.rsp.size = leafSize;
                        d.lastPa = leafPa;
                        d.walks = q.walks + 32'h0000_0001;
                        d.walk = ptm_pkg::WS_IDLE;
                    end else begin
                        d.level = q.level - 3'h1;
                        d.fetch.addr = tableAddr(q.mode, q.level - 3'h1, nextBase, q.vaddr);
                    end
                end
            end
            default: begin
                d.walk = ptm_pkg::WS_IDLE;
                d.fetch.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstnInt) begin
        if (!rstnInt) begin
            q.pg <= `PTM_RST_BIT;
            q.phys_addr_extension_bit <= `PTM_RST_BIT;
            q.large_page_size_ext_bit <= `PTM_RST_BIT;
            q.lme <= `PTM_RST_BIT;
            q.baseLo <= `PTM_RST_WORD;
            q.baseHi <= `PTM_RST_HI;
            q.rdData <= `PTM_RST_WORD;
            q.walk <= ptm_pkg::WS_IDLE;
            q.level <= 3'h0;
            q.mode <= ptm_pkg::PM_OFF;
            q.vaddr <= 48'h0000_0000_0000;
            q.fetch <= '0;
            q.rsp <= '0;
            q.lastPa <= `PTM_RST_PA;
            q.walks <= `PTM_RST_WORD;
        end else if (ce) begin
            q <= d;
        end
    end

    assign regRData = q.rdData;
    assign reqReady = (q.walk == ptm_pkg::WS_IDLE);
    assign rsp = q.rsp;
    assign rspPaddr = q.rsp.paddr[PA_W-1:0];
    assign fetch = q.fetch;
    assign modeNow = curMode;
    assign longActive = long_mode_active_flag;

endmodule // ptm_translate_core

`default_nettype wire

// ==== sim/ptm_checker.sv ====
// ptm_checker: port-level assertions for the translation core
// assumes it is bound into ptm_translate_core and runs on mclk alone
`include "ptm_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module ptm_checker (
    input wire logic                   mclk,
    input wire logic                   rstn,
    input wire logic                   ce,
    input wire logic [`PTM_ADDR_W-1:0] regAddr,
    input wire logic [31:0]            regWData,
    input wire logic                   regWr,
    input wire ptm_pkg::ptm_req_s      req,
    input wire logic                   reqReady,
    input wire ptm_pkg::ptm_rsp_s      rsp,
    input wire ptm_pkg::ptm_fetch_s    fetch,
    input wire ptm_pkg::ptm_mem_s      mem,
    input wire ptm_pkg::ptm_mode_e     modeNow,
    input wire logic                   longActive
);
    wire logic        take  = ce && req.valid && reqReady;
    wire logic        wr0   = ce && regWr && regAddr == `PTM_OFF_CTL0;
    wire logic        wr4   = ce && regWr && regAddr == `PTM_OFF_CTL4;
    wire logic        extIn = regWData[`PTM_BIT_PAE];
    wire logic [31:0] vLo   = req.vaddr[31:0];
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_paging_off; wr0 && !regWData[31] |=> modeNow == ptm_pkg::PM_OFF && !longActive; endproperty
    a_paging_off: assert property (p_paging_off) else $error("mode not off after clear");
    property p_paging_on; wr0 && regWData[31] |=> modeNow != ptm_pkg::PM_OFF; endproperty
    a_paging_on: assert property (p_paging_on) else $error("mode off after set");
    property p_ext_sel;
        wr4 && modeNow != ptm_pkg::PM_OFF && !longActive
        |=> modeNow == ($past(extIn) ? ptm_pkg::PM_LEGPAE : ptm_pkg::PM_LEG32);
    endproperty
    a_ext_sel: assert property (p_ext_sel) else $error("legacy mode wrong after control write");
    property p_long_mode; longActive |-> modeNow == ptm_pkg::PM_LONG; endproperty
    a_long_mode: assert property (p_long_mode) else $error("long active without long mode");
    property p_long_act; modeNow == ptm_pkg::PM_LONG |-> longActive; endproperty
    a_long_act: assert property (p_long_act) else $error("long mode without long active");
    property p_off_nofetch; take && modeNow == ptm_pkg::PM_OFF |=> rsp.valid && !fetch.valid; endproperty
    a_off_nofetch: assert property (p_off_nofetch) else $error("paging off answer late or fetched");
    property p_off_addr;
        take && modeNow == ptm_pkg::PM_OFF
        |=> rsp.paddr == {20'h0_0000, $past(vLo)} && rsp.size == ptm_pkg::PS_4K;
    endproperty
    a_off_addr: assert property (p_off_addr) else $error("paging off address changed");
    property p_narrow; take && modeNow == ptm_pkg::PM_LEG32 |=> fetch.valid && !fetch.wide; endproperty
    a_narrow: assert property (p_narrow) else $error("plain legacy fetch not narrow");
    property p_wide;
        take && (modeNow == ptm_pkg::PM_LEGPAE || modeNow == ptm_pkg::PM_LONG) |=> fetch.valid && fetch.wide;
    endproperty
    a_wide: assert property (p_wide) else $error("extended fetch not wide");
    property p_hold; fetch.valid && !mem.valid |=> fetch.valid && $stable(fetch.addr); endproperty
    a_hold: assert property (p_hold) else $error("fetch dropped before answer");
    c_long: cover property (take && modeNow == ptm_pkg::PM_LONG);
    c_giga: cover property (rsp.valid && rsp.size == ptm_pkg::PS_1G);
    c_four: cover property (rsp.valid && rsp.size == ptm_pkg::PS_4M);
endmodule // ptm_checker
bind ptm_translate_core ptm_checker chk (
    .mclk(mclk), .rstn(rstn), .ce(ce), .regAddr(regAddr), .regWData(regWData), .regWr(regWr),
    .req(req), .reqReady(reqReady), .rsp(rsp), .fetch(fetch), .mem(mem), .modeNow(modeNow),
    .longActive(longActive));
`default_nettype wire

// ==== sim/ptm_mem_model.sv ====
// ptm_mem_model: page table memory answering entry fetches
// assumes fetch.valid holds until answered; stopAt picks the entry with the size bit
`timescale 1ns/1ns
`default_nettype none
module ptm_mem_model (
    input  wire logic          mclk,
    input  wire logic          rstn,
    input  wire ptm_pkg::ptm_fetch_s fetch,
    input  wire logic [2:0]    stopAt,
    input  wire logic [1:0]    delay,
    output ptm_pkg::ptm_mem_s  mem
);
    logic [2:0] lvl;
    logic [1:0] cnt;
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mem <= '0;
            lvl <= 3'h0;
            cnt <= 2'h0;
        end else if (mem.valid) begin
            // one-cycle answer, then data turns to noise
            mem.valid <= 1'b0;
            mem.data  <= ~mem.data;
            lvl       <= lvl + 3'h1;
            cnt       <= 2'h0;
        end else if (!fetch.valid) begin
            mem.data <= ~mem.data;
            lvl      <= 3'h0;
            cnt      <= 2'h0;
        end else if (cnt == delay) begin
            mem.valid <= 1'b1;
            mem.data  <= 64'h0000_0ABC_DEF0_1000 | (lvl == stopAt ? 64'h80 : 64'h0);
        end else begin
            mem.data <= ~mem.data;
            cnt      <= cnt + 2'h1;
        end
    end
endmodule // ptm_mem_model
`default_nettype wire

// ==== sim/testbench.sv ====
// testbench: mode table walk through the translation core
// assumes ptm_mem_model answers fetches and the checker is bound
`include "ptm_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
    typedef struct packed {
        logic [3:0]         ctl;
        logic [2:0]         stopAt;
        ptm_pkg::ptm_mode_e mode;
        ptm_pkg::ptm_size_e size;
        logic [2:0]         lvls;
    } ptm_row_s;
    localparam logic [63:0] VA = 64'h0000_7654_3FED_CBA9;
    // entry the table model returns, size bit clear
    localparam logic [63:0] ENT = 64'h0000_0ABC_DEF0_1000;
    logic [51:0]         pa, fa, ta;
    logic                mclk, rstn, ce, regWr, regRd, reqReady, longActive;
    logic [7:0]          regAddr;
    logic [31:0]         regWData, regRData, d;
    logic [39:0]         rspPaddr;
    logic [2:0]          stopAt, lvls;
    logic [1:0]          delay;
    logic [63:0]         mask;
    ptm_pkg::ptm_req_s   req;
    ptm_pkg::ptm_rsp_s   rsp;
    ptm_pkg::ptm_fetch_s fetch;
    ptm_pkg::ptm_mem_s   mem;
    ptm_pkg::ptm_mode_e  modeNow;
    ptm_row_s            r;
    int                  nErrors, checksDone, cycles;
    // ctl is {paging, extensions, large size, long enable}
    ptm_row_s rows[10] = '{
        '{4'b0000, 3'd7, ptm_pkg::PM_OFF, ptm_pkg::PS_4K, 3'd0},
        '{4'b1000, 3'd0, ptm_pkg::PM_LEG32, ptm_pkg::PS_4K, 3'd2},
        '{4'b1010, 3'd0, ptm_pkg::PM_LEG32, ptm_pkg::PS_4M, 3'd1},
        '{4'b1010, 3'd7, ptm_pkg::PM_LEG32, ptm_pkg::PS_4K, 3'd2},
        '{4'b1110, 3'd1, ptm_pkg::PM_LEGPAE, ptm_pkg::PS_2M, 3'd2},
        '{4'b1100, 3'd0, ptm_pkg::PM_LEGPAE, ptm_pkg::PS_4K, 3'd3},
        '{4'b1101, 3'd7, ptm_pkg::PM_LONG, ptm_pkg::PS_4K, 3'd4},
        '{4'b1101, 3'd1, ptm_pkg::PM_LONG, ptm_pkg::PS_1G, 3'd2},
        '{4'b1111, 3'd2, ptm_pkg::PM_LONG, ptm_pkg::PS_2M, 3'd3},
        '{4'b0101, 3'd7, ptm_pkg::PM_OFF, ptm_pkg::PS_4K, 3'd0}};
    ptm_translate_core #(.PA_W(40)) uut (
        .mclk(mclk), .rstn(rstn), .ce(ce), .regAddr(regAddr), .regWData(regWData), .regWr(regWr),
        .regRd(regRd), .regRData(regRData), .req(req), .reqReady(reqReady), .rsp(rsp),
        .rspPaddr(rspPaddr), .fetch(fetch), .mem(mem), .modeNow(modeNow), .longActive(longActive));
    ptm_mem_model pt (.mclk(mclk), .rstn(rstn), .fetch(fetch), .stopAt(stopAt), .delay(delay), .mem(mem));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic endSim;
        $display("checks %0d errors %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        regAddr  <= a;
        regWData <= v;
        regWr    <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRData;
    endtask
    task automatic xfer;
        @(posedge mclk);
        req <= '{1'b1, VA};
        @(posedge mclk);
        req.valid <= 1'b0;
        lvls = 3'h0;
        for (int n = 0; n < 40; n++) begin
            #1;
            if (n == 0) fa = fetch.addr;
            if (rsp.valid) break;
            if (mem.valid) lvls++;
            @(posedge mclk);
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            nErrors++;
            endSim;
        end
    end
    initial begin
        {rstn, regWr, regRd, regAddr, regWData} = '0;
        {ce, stopAt, delay, req} = {1'b1, 3'd7, 2'd0, 65'h0};
        {nErrors, checksDone, cycles} = '0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            r = rows[i];
            stopAt <= r.stopAt;
            delay  <= 2'(i % 3);
            wr(`PTM_OFF_CTL0, {r.ctl[3], 31'h0});
            wr(`PTM_OFF_CTL4, {26'h0, r.ctl[2:1], 4'h0});
            wr(`PTM_OFF_EXTF, {23'h0, r.ctl[0], 8'h0});
            rd(`PTM_OFF_EXTF);
            check("long active bit", d[10], r.ctl[3] & r.ctl[0]);
            check("mode", modeNow, r.mode);
            xfer();
            mask = (r.size == ptm_pkg::PS_1G) ? 64'h3FFF_FFFF : (r.size == ptm_pkg::PS_4M) ? 64'h3F_FFFF :
                   (r.size == ptm_pkg::PS_2M) ? 64'h1F_FFFF : 64'hFFF;
            if (r.mode == ptm_pkg::PM_OFF) mask = 64'hFFFF_FFFF;
            pa = (r.mode == ptm_pkg::PM_OFF) ? {20'h0, VA[31:0]} :
                 (r.size == ptm_pkg::PS_4M) ? {12'h0, ENT[20:13], ENT[31:22], VA[21:0]} :
                 (r.size == ptm_pkg::PS_2M) ? {ENT[51:21], VA[20:0]} :
                 (r.size == ptm_pkg::PS_1G) ? {ENT[51:30], VA[29:0]} :
                 (r.mode == ptm_pkg::PM_LEG32) ? {20'h0, ENT[31:12], VA[11:0]} : {ENT[51:12], VA[11:0]};
            ta = (r.mode == ptm_pkg::PM_LEG32) ? {40'h0, VA[31:22], 2'h0} :
                 (r.mode == ptm_pkg::PM_LEGPAE) ? {47'h0, VA[31:30], 3'h0} : {40'h0, VA[47:39], 3'h0};
            check("answer", rsp.valid, 1'b1);
            check("size", rsp.size, r.size);
            check("offset", rsp.paddr & mask[51:0], VA & mask);
            check("walk levels", lvls, r.lvls);
            check("narrow paddr", rspPaddr, pa[39:0]);
            check("paddr", rsp.paddr, pa);
            check("ready after answer", reqReady, 1'b1);
            if (r.mode != ptm_pkg::PM_OFF) check("first table", fa, ta);
        end
        // paging off, two requests back to back
        @(posedge mclk);
        req <= '{1'b1, VA};
        @(posedge mclk);
        req <= '{1'b1, ~VA};
        #1 check("first pass", rsp.paddr, {20'h0, VA[31:0]});
        @(posedge mclk);
        req.valid <= 1'b0;
        #1 check("second pass", rsp.paddr, {20'h0, ~VA[31:0]});
        wr(8'h3C, 32'hFFFF_FFFF);
        rd(8'h3C);
        check("unmapped read", d, 32'h0);
        wr(`PTM_OFF_CTL0, 32'h8000_0000);
        @(posedge mclk);
        rstn <= 1'b0;
        #1 check("mode in reset", modeNow, ptm_pkg::PM_OFF);
        check("long in reset", longActive, 1'b0);
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(`PTM_OFF_CTL0);
        check("paging after reset", d[31], 1'b0);
        endSim;
    end
endmodule // testbench
`default_nettype wire
